// file: src/cmpev_cfg.svh
// offsets, bit positions, reset values and timing for the comparator event block
`ifndef CMPEV_CFG_SVH
`define CMPEV_CFG_SVH

`define CMPEV_ADDR_W          4
`define CMPEV_CTRL_OFFSET     4'h0
`define CMPEV_IRQ_STAT_OFFSET 4'h4
`define CMPEV_IRQ_MASK_OFFSET 4'h8

`define CMPEV_BIT_PWR_OFF     7
`define CMPEV_BIT_RESV6       6
`define CMPEV_BIT_RESULT      5
`define CMPEV_BIT_FLAG        4
`define CMPEV_BIT_IRQ_EN      3
`define CMPEV_BIT_RESV2       2
`define CMPEV_BIT_MODE_HI     1
`define CMPEV_BIT_MODE_LO     0

`define CMPEV_CTRL_RESET      8'h00
`define CMPEV_CTRL_WR_MASK    8'h8B
`define CMPEV_IRQ_RESET       2'h0

// irq status bits: 0 comparator event, 1 vector entry
`define CMPEV_IRQ_W           2
`define CMPEV_IRQ_EVENT       0
`define CMPEV_IRQ_VECTOR      1

// comparator output settles after power-up before edges count
`define CMPEV_SETTLE_NS       50
`define CMPEV_CLK_NS          10
`define CMPEV_SETTLE_CYC      ((`CMPEV_SETTLE_NS + `CMPEV_CLK_NS - 1) / `CMPEV_CLK_NS)

`endif

// file: src/cmpev_edge.sv
// comparator result synchroniser and transition detector
`timescale 1ns/100ps
`default_nettype none

module cmpev_edge (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic raw_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // two stages before any logic reads the analog output
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign level = sync2_reg;
  assign rise  = sync2_reg & ~prev_reg;
  assign fall  = ~sync2_reg & prev_reg;

endmodule : cmpev_edge

`default_nettype wire

// file: src/cmpev_pkg.sv
// types for the comparator event block
package cmpev_pkg;

  typedef enum logic [1:0] {
    CMPEV_MODE_TOGGLE  = 2'h0,
    CMPEV_MODE_RESV    = 2'h1,
    CMPEV_MODE_FALLING = 2'h2,
    CMPEV_MODE_RISING  = 2'h3
  } cmpev_mode_e;

  typedef enum logic [2:0] {
    CMPEV_ST_OFF    = 3'h1,
    CMPEV_ST_SETTLE = 3'h2,
    CMPEV_ST_RUN    = 3'h4
  } cmpev_state_e;

endpackage : cmpev_pkg

// file: src/cmpev_top.sv
// comparator control/status register, event flag and interrupt logic
`timescale 1ns/100ps
`default_nettype none
`include "cmpev_cfg.svh"

module cmpev_top (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic [`CMPEV_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  output logic      [7:0]               reg_rdata,
  input  wire logic                     comparator_out,
  input  wire logic                     global_irq_enable,
  input  wire logic                     vector_ack,
  output logic                          comparator_power_off,
  output logic                          comparator_irq_req,
  output logic                          irq
);

  logic                    pwr_off_reg;
  logic                    pwr_off_next;
  logic                    flag_reg;
  logic                    flag_next;
  logic                    irq_en_reg;
  logic                    irq_en_next;
  logic [1:0]              mode_reg;
  logic [1:0]              mode_next;
  logic [`CMPEV_IRQ_W-1:0] istat_reg;
  logic [`CMPEV_IRQ_W-1:0] istat_next;
  logic [`CMPEV_IRQ_W-1:0] imask_reg;
  logic [`CMPEV_IRQ_W-1:0] imask_next;
  logic [7:0]              rdata_reg;
  logic [7:0]              rdata_next;
  logic                    req_reg;
  logic                    irq_reg;
  logic                    pwr_pin_reg;
  logic [2:0]              cnt_reg;
  logic [2:0]              cnt_next;
  cmpev_pkg::cmpev_state_e state_reg;
  cmpev_pkg::cmpev_state_e state_next;

  wire logic       level;
  wire logic       rise;
  wire logic       fall;
  wire logic       sel_ctrl;
  wire logic       sel_stat;
  wire logic       sel_mask;
  wire logic       wr_ctrl;
  wire logic       wr_stat;
  wire logic       wr_mask;
  wire logic       running;
  wire logic       event_hit;
  wire logic       flag_clear;
  wire logic [7:0] ctrl_view;
  wire logic [7:0] rd_mux;

  function automatic logic mode_match(input logic [1:0] mode,
                                      input logic       up,
                                      input logic       down);
    case (mode)
      cmpev_pkg::CMPEV_MODE_TOGGLE:  mode_match = up | down;
      cmpev_pkg::CMPEV_MODE_FALLING: mode_match = down;
      cmpev_pkg::CMPEV_MODE_RISING:  mode_match = up;
      default:                       mode_match = 1'b0;
    endcase
  endfunction

  cmpev_edge u_edge (
    .core_clk (core_clk),
    .reset    (reset),
    .raw_in   (comparator_out),
    .level    (level),
    .rise     (rise),
    .fall     (fall)
  );

  // address decode
  assign sel_ctrl = (reg_addr == `CMPEV_CTRL_OFFSET);
  assign sel_stat = (reg_addr == `CMPEV_IRQ_STAT_OFFSET);
  assign sel_mask = (reg_addr == `CMPEV_IRQ_MASK_OFFSET);
  assign wr_ctrl  = reg_write & sel_ctrl;
  assign wr_stat  = reg_write & sel_stat;
  assign wr_mask  = reg_write & sel_mask;

  // power state: edges are ignored while off and while output settles
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      cmpev_pkg::CMPEV_ST_OFF: begin
        if (!pwr_off_reg) begin
          state_next = cmpev_pkg::CMPEV_ST_SETTLE;
          cnt_next   = 3'h0;
        end
      end
      cmpev_pkg::CMPEV_ST_SETTLE: begin
        if (pwr_off_reg) begin
          state_next = cmpev_pkg::CMPEV_ST_OFF;
        end else if (cnt_reg == 3'(`CMPEV_SETTLE_CYC - 1)) begin
          state_next = cmpev_pkg::CMPEV_ST_RUN;
        end else begin
          cnt_next = cnt_reg + 3'h1;
        end
      end
      cmpev_pkg::CMPEV_ST_RUN: begin
        if (pwr_off_reg) begin
          state_next = cmpev_pkg::CMPEV_ST_OFF;
        end
      end
      default: begin
        state_next = cmpev_pkg::CMPEV_ST_OFF;
      end
    endcase
  end

  assign running = (state_reg == cmpev_pkg::CMPEV_ST_RUN);

  assign event_hit  = running & mode_match(mode_reg, rise, fall);
  assign flag_clear = vector_ack |
                      (wr_ctrl & reg_wdata[`CMPEV_BIT_FLAG]);

  assign flag_next = event_hit ? 1'b1 : (flag_clear ? 1'b0 : flag_reg);

  assign pwr_off_next = wr_ctrl ? reg_wdata[`CMPEV_BIT_PWR_OFF] : pwr_off_reg;
  assign irq_en_next  = wr_ctrl ? reg_wdata[`CMPEV_BIT_IRQ_EN] : irq_en_reg;
  assign mode_next    = wr_ctrl ?
                        reg_wdata[`CMPEV_BIT_MODE_HI:`CMPEV_BIT_MODE_LO] :
                        mode_reg;

  // sticky status, write one to clear, set wins
  assign istat_next = ({event_hit, vector_ack} == 2'h0 ? istat_reg :
                       istat_reg) & ~(wr_stat ? reg_wdata[1:0] : 2'h0)
                      | {vector_ack, event_hit};
  assign imask_next = wr_mask ? reg_wdata[1:0] : imask_reg;

  assign ctrl_view = {pwr_off_reg, 1'b0, level, flag_reg,
                      irq_en_reg, 1'b0, mode_reg};

  assign rd_mux = sel_ctrl ? ctrl_view :
                  sel_stat ? {6'h00, istat_reg} :
                  sel_mask ? {6'h00, imask_reg} :
                  8'h00;
  assign rdata_next = reg_read ? rd_mux : 8'h00;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pwr_off_reg <= 1'b0;
      flag_reg    <= 1'b0;
      irq_en_reg  <= 1'b0;
      mode_reg    <= 2'h0;
      istat_reg   <= `CMPEV_IRQ_RESET;
      imask_reg   <= `CMPEV_IRQ_RESET;
      rdata_reg   <= 8'h00;
      state_reg   <= cmpev_pkg::CMPEV_ST_SETTLE;
      cnt_reg     <= 3'h0;
    end else begin
      pwr_off_reg <= pwr_off_next;
      flag_reg    <= flag_next;
      irq_en_reg  <= irq_en_next;
      mode_reg    <= mode_next;
      istat_reg   <= istat_next;
      imask_reg   <= imask_next;
      rdata_reg   <= rdata_next;
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
    end
  end

  // outputs come straight from flops; loaded from the next-state values, so they change in the same cycle as the state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      req_reg     <= 1'b0;
      irq_reg     <= 1'b0;
      pwr_pin_reg <= 1'b0;
    end else begin
      req_reg     <= flag_next & irq_en_next & global_irq_enable;
      irq_reg     <= |(istat_next & imask_next);
      pwr_pin_reg <= pwr_off_next;
    end
  end

  assign reg_rdata            = rdata_reg;
  assign comparator_irq_req   = req_reg;
  assign irq                  = irq_reg;
  assign comparator_power_off = pwr_pin_reg;

endmodule : cmpev_top

`default_nettype wire

// file: verification/cmpev_analog_model.sv
// behavioural analog comparator on the far side
`timescale 1ns/100ps
`default_nettype none
module cmpev_analog_model (
  input  wire logic power_off,
  input  wire logic above,
  output logic      comparator_out
);
  logic last_on = 1'b0;
  always @* if (!power_off) last_on = above;
  // unpowered output is junk, not last level
  assign #3 comparator_out = power_off ? ~last_on : above;
endmodule // cmpev_analog_model
`default_nettype wire

// file: verification/cmpev_checker.sv
// port assertions for the comparator event block
`timescale 1ns/100ps
`default_nettype none
module cmpev_checker (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       comparator_out,
  input wire logic       global_irq_enable,
  input wire logic       vector_ack,
  input wire logic       comparator_power_off,
  input wire logic       comparator_irq_req,
  input wire logic       irq
);
  logic       prev_reg;
  logic [2:0] calm_reg;
  wire        rd0 = reg_read && reg_addr == 4'h0;
  wire        wr0 = reg_write && reg_addr == 4'h0;
  // quiet-input count: no event may still be in the pipe
  always_ff @(posedge core_clk) begin
    prev_reg <= comparator_out;
    if (reset || comparator_out != prev_reg)
      calm_reg <= 3'h0;
    else if (calm_reg != 3'h7)
      calm_reg <= calm_reg + 3'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_RD_ONE_CYCLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_RESV_ZERO: assert property (
    $past(rd0) |-> !reg_rdata[6] && !reg_rdata[2])
    else $error("unused bits not zero");
  AST_PWR_FOLLOWS: assert property (
    wr0 |-> ##2 comparator_power_off == $past(reg_wdata[7], 2))
    else $error("power off not written");
  AST_REQ_GLOBAL: assert property (
    !$past(global_irq_enable) |-> !comparator_irq_req)
    else $error("request without global enable");
  AST_REQ_DISABLE: assert property (
    wr0 && !reg_wdata[3] ##1 !reg_write |=> !comparator_irq_req)
    else $error("request after enable cleared");
  // four quiet cycles: sync pipe holds no pending edge
  AST_RESULT_LIVE: assert property (
    calm_reg[2] && rd0 && !comparator_power_off
    |=> reg_rdata[5] == $past(comparator_out))
    else $error("result bit wrong");
  // bench leaves one idle cycle between a write and the next read
  AST_WR1_CLEARS: assert property (
    calm_reg[2] && wr0 && reg_wdata[4] ##2 rd0 |=> !reg_rdata[4])
    else $error("flag not cleared by write");
  AST_VEC_CLEARS: assert property (
    calm_reg[2] && vector_ack ##2 rd0 |=> !reg_rdata[4])
    else $error("flag not cleared by vector");
  cover property (comparator_irq_req);
  cover property (irq);
  cover property (vector_ack && comparator_irq_req);
endmodule // cmpev_checker
bind cmpev_top cmpev_checker u_chk (.*);
`default_nettype wire

// file: verification/cmpev_tb_top.sv
// self-checking bench for the comparator event block
`timescale 1ns/100ps
`default_nettype none
module cmpev_tb_top;
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       global_irq_enable = 1'b0;
  logic       vector_ack = 1'b0;
  logic       above = 1'b0;
  logic [7:0] reg_rdata;
  logic       comparator_out;
  logic       comparator_power_off;
  logic       comparator_irq_req;
  logic       irq;
  int         n_errors = 0;
  int         tests_run = 0;
  int         seed = 32'h4361973A;
  int         m;
  int         v;
  int         flag;
  always #5 core_clk = ~core_clk;
  cmpev_top dut (.*);
  cmpev_analog_model u_ana (.power_off(comparator_power_off),
    .above(above), .comparator_out(comparator_out));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // event reaches the flag about three cycles after the input moves
  task automatic step(input logic lvl);
    above <= lvl;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic final_report;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'hC, 8'h00);
    for (m = 0; m < 8; m++) begin
      // enable stays off across mode changes
      wr(4'h0, 8'h54 | m[2:1]);
      step(!m[0]);
      flag = m[2:1] == 0 || m[2:1] == 3 && !m[0] || m[2:1] == 2 && m[0];
      rd(4'h0, {2'b00, !m[0], flag[0], 2'b00, m[2:1]});
    end
    wr(4'h8, 8'h01);
    wr(4'h0, 8'h0B);
    global_irq_enable <= 1'b1;
    step(1'b1);
    chk({comparator_irq_req, irq}, 8'h03);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(comparator_irq_req, 8'h00);
    global_irq_enable <= 1'b1;
    vector_ack <= 1'b1;
    @(posedge core_clk);
    vector_ack <= 1'b0;
    rd(4'h0, 8'h2B);
    rd(4'h4, 8'h03);
    wr(4'h4, 8'h03);
    rd(4'h4, 8'h00);
    chk({comparator_irq_req, irq}, 8'h00);
    step(1'b0);
    step(1'b1);
    // rewrite of the enable bit with flag cleared and read back as zero
    wr(4'h0, 8'h13);
    rd(4'h0, 8'h23);
    // enable already off before power change
    wr(4'h0, 8'h83);
    repeat (2) @(posedge core_clk);
    chk(comparator_power_off, 8'h01);
    wr(4'h0, 8'h03);
    repeat (2) @(posedge core_clk);
    chk(comparator_power_off, 8'h00);
    for (m = 0; m < 4; m++) begin
      v = $random(seed);
      wr(4'h8, v[7:0]);
      rd(4'h8, {6'h00, v[1:0]});
    end
    final_report();
  end
endmodule // cmpev_tb_top
`default_nettype wire
